/* rtl/ctp_defines.svh */
`ifndef CTP_DEFINES_SVH
`define CTP_DEFINES_SVH
// ------------------------------------------------------------
// control bits of the upper counter control byte
// ------------------------------------------------------------
`define CTP_RUN_BIT 3
`define CTP_FF_INIT_BIT 7
// ------------------------------------------------------------
// lower counter control byte fields
// ------------------------------------------------------------
`define CTP_CLK_SEL_LSB 4
`define CTP_CLK_SEL_MSB 6
// ------------------------------------------------------------
// prescaler taps
// ------------------------------------------------------------
`define CTP_PRE_W 11
`define CTP_TAP_11 10
`define CTP_TAP_7 6
`define CTP_TAP_5 4
`define CTP_TAP_3 2
`define CTP_TAP_1 0
`define CTP_FS_TAP_3 2
`define CTP_FS_PRE_W 3
// ------------------------------------------------------------
// reset values, counter limit and count step
// ------------------------------------------------------------
`define CTP_CNT_RST 16'h0000
`define CTP_CNT_MAX 16'hFFFF
`define CTP_CNT_ONE 16'h0001
`define CTP_BYTE_RST 8'h00
`endif

/* rtl/ctp_pkg.sv */
package ctp_pkg;
  typedef enum logic [1:0] {
    CTP_MODE_TIMER = 2'b00,
    CTP_MODE_EVENT = 2'b01,
    CTP_MODE_PWM = 2'b10,
    CTP_MODE_RSVD = 2'b11
  } ctp_mode_e;
  typedef enum logic [2:0] {
    CTP_CLK_D11 = 3'b000,
    CTP_CLK_D7 = 3'b001,
    CTP_CLK_D5 = 3'b010,
    CTP_CLK_D3 = 3'b011,
    CTP_CLK_FS = 3'b100,
    CTP_CLK_D1 = 3'b101,
    CTP_CLK_FC = 3'b110,
    CTP_CLK_EXT = 3'b111
  } ctp_clk_e;
endpackage

/* rtl/ctp_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ctp_defines.svh"
module ctp_prescaler
  import ctp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic slow_mode,
  input wire logic divider_source_select,
  input wire logic fs_tick,
  input wire ctp_clk_e clk_sel,
  input wire logic pwm_mode,
  output logic tick
);
  logic [`CTP_PRE_W-1:0] pre_reg;
  logic [`CTP_PRE_W-1:0] pre_next;
  logic [`CTP_FS_PRE_W-1:0] fs_reg;
  logic [`CTP_FS_PRE_W-1:0] fs_next;
  logic [`CTP_PRE_W-1:0] rise;
  logic fs_rise;

  // ------------------------------------------------------------
  // dividers of fc and fs, held at zero while run is low
  // ------------------------------------------------------------
  always_comb begin
    pre_next = run ? pre_reg + 1'b1 : '0;
    fs_next = (run && fs_tick) ? fs_reg + 1'b1 : (run ? fs_reg : '0);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= '0;
      fs_reg <= '0;
    end else begin
      pre_reg <= pre_next;
      fs_reg <= fs_next;
    end
  end

  // tick when a divider bit would go high on this edge
  assign rise = pre_next & ~pre_reg;
  assign fs_rise = fs_tick && (fs_next[`CTP_FS_TAP_3] && !fs_reg[`CTP_FS_TAP_3]);

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  always_comb begin
    tick = 1'b0;
    if (slow_mode) begin
      if (clk_sel == CTP_CLK_D11) begin
        tick = fs_rise;
      end else if (clk_sel == CTP_CLK_FS && pwm_mode) begin
        tick = fs_tick;
      end
    end else begin
      case (clk_sel)
        CTP_CLK_D11: tick = divider_source_select ? fs_rise : rise[`CTP_TAP_11];
        CTP_CLK_D7: tick = rise[`CTP_TAP_7];
        CTP_CLK_D5: tick = rise[`CTP_TAP_5];
        CTP_CLK_D3: tick = rise[`CTP_TAP_3];
        CTP_CLK_FS: tick = pwm_mode && fs_tick;
        CTP_CLK_D1: tick = pwm_mode && rise[`CTP_TAP_1];
        CTP_CLK_FC: tick = pwm_mode && run;
        default: tick = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* rtl/ctp_edge_detect.sv */
`timescale 1ns/1ns
`default_nettype none
module ctp_edge_detect (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  output logic fall
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;

  // ------------------------------------------------------------
  // two-stage synchroniser then falling edge of two samples
  // ------------------------------------------------------------
  always_comb begin
    sync_next = {sync_reg[1:0], pin};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_reg <= 3'h7;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign fall = sync_reg[2] && !sync_reg[1];
endmodule
`default_nettype wire

/* rtl/ctp_timer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "ctp_defines.svh"
module ctp_timer
  import ctp_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] lower_counter_control,
  input wire logic [7:0] upper_counter_control,
  input wire ctp_mode_e mode,
  input wire logic slow_mode,
  input wire logic divider_source_select,
  input wire logic fs_tick,
  input wire logic external_count_pin,
  input wire logic [7:0] wr_data,
  input wire logic match_value_low_wr,
  input wire logic match_value_high_wr,
  input wire logic duty_value_low_wr,
  input wire logic duty_value_high_wr,
  output logic [7:0] duty_value_low,
  output logic [7:0] duty_value_high,
  output logic [15:0] count_value,
  output logic match_overflow_interrupt,
  output logic pwm_output_pin,
  output logic output_flipflop
);
  logic [7:0] match_lo_reg;
  logic [7:0] match_lo_next;
  logic [7:0] match_hi_reg;
  logic [7:0] match_hi_next;
  logic [15:0] duty_buf_reg;
  logic [15:0] duty_buf_next;
  logic [15:0] duty_act_reg;
  logic [15:0] duty_act_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic ff_reg;
  logic ff_next;
  logic irq_reg;
  logic irq_next;
  logic run_reg;
  logic run_next;
  logic init_reg;
  logic init_next;
  logic [7:0] dlo_reg;
  logic [7:0] dlo_next;
  logic [7:0] dhi_reg;
  logic [7:0] dhi_next;
  logic run;
  logic ff_init;
  logic tick;
  logic ext_fall;
  logic step;
  logic is_pwm;
  logic use_ext;
  logic [15:0] match_val;
  ctp_clk_e clk_sel;

  function automatic logic [15:0] ctp_join(input logic [7:0] hi, input logic [7:0] lo);
    ctp_join = {hi, lo};
  endfunction

  assign run = upper_counter_control[`CTP_RUN_BIT];
  assign ff_init = upper_counter_control[`CTP_FF_INIT_BIT];
  assign clk_sel = ctp_clk_e'(lower_counter_control[`CTP_CLK_SEL_MSB:`CTP_CLK_SEL_LSB]);
  assign is_pwm = (mode == CTP_MODE_PWM);
  assign use_ext = (mode == CTP_MODE_EVENT) || (is_pwm && clk_sel == CTP_CLK_EXT);

  // ------------------------------------------------------------
  // count sources
  // ------------------------------------------------------------
  ctp_prescaler u_pre (
    .clk(clk),
    .resetn(resetn),
    .run(run),
    .slow_mode(slow_mode),
    .divider_source_select(divider_source_select),
    .fs_tick(fs_tick),
    .clk_sel(clk_sel),
    .pwm_mode(is_pwm),
    .tick(tick)
  );

  ctp_edge_detect u_edge (
    .clk(clk),
    .resetn(resetn),
    .pin(external_count_pin),
    .fall(ext_fall)
  );

  assign step = run && (use_ext ? ext_fall : tick);
  assign match_val = ctp_join(match_hi_reg, match_lo_reg);

  // ------------------------------------------------------------
  // registers written by software
  // ------------------------------------------------------------
  always_comb begin
    match_lo_next = match_value_low_wr ? wr_data : match_lo_reg;
    match_hi_next = match_value_high_wr ? wr_data : match_hi_reg;
    duty_buf_next = duty_buf_reg;
    if (duty_value_low_wr) begin
      duty_buf_next[7:0] = wr_data;
    end
    if (duty_value_high_wr) begin
      duty_buf_next[15:8] = wr_data;
    end
  end

  // ------------------------------------------------------------
  // counter, flip-flop, duty transfer
  // ------------------------------------------------------------
  always_comb begin
    cnt_next = cnt_reg;
    ff_next = ff_reg;
    irq_next = 1'b0;
    duty_act_next = duty_act_reg;
    run_next = run;
    init_next = ff_init;
    if (!run) begin
      duty_act_next = duty_buf_next;
      // a stop holds the level; only a later move of the init bit loads it
      // so the held level survives any number of stopped cycles
      if (!run_reg && ff_init != init_reg) begin
        ff_next = ff_init;
      end
      cnt_next = `CTP_CNT_RST;
    end else if (step) begin
      if (is_pwm) begin
        if (cnt_reg == `CTP_CNT_MAX) begin
          cnt_next = `CTP_CNT_RST;
          ff_next = !ff_reg;
          irq_next = 1'b1;
          duty_act_next = duty_buf_reg;
        end else begin
          cnt_next = cnt_reg + `CTP_CNT_ONE;
          if (cnt_next == duty_act_reg) begin
            ff_next = !ff_reg;
          end
        end
      end else begin
        cnt_next = cnt_reg + `CTP_CNT_ONE;
        if (cnt_next == match_val) begin
          cnt_next = `CTP_CNT_RST;
          irq_next = 1'b1;
        end
      end
    end
    // readback of the active value until the transfer while pwm runs, else of the buffer
    dlo_next = (is_pwm && run) ? duty_act_next[7:0] : duty_buf_next[7:0];
    dhi_next = (is_pwm && run) ? duty_act_next[15:8] : duty_buf_next[15:8];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      match_lo_reg <= `CTP_BYTE_RST;
      match_hi_reg <= `CTP_BYTE_RST;
      duty_buf_reg <= `CTP_CNT_RST;
      duty_act_reg <= `CTP_CNT_RST;
      cnt_reg <= `CTP_CNT_RST;
      ff_reg <= 1'b0;
      irq_reg <= 1'b0;
      run_reg <= 1'b0;
      init_reg <= 1'b0;
      dlo_reg <= `CTP_BYTE_RST;
      dhi_reg <= `CTP_BYTE_RST;
    end else begin
      match_lo_reg <= match_lo_next;
      match_hi_reg <= match_hi_next;
      duty_buf_reg <= duty_buf_next;
      duty_act_reg <= duty_act_next;
      cnt_reg <= cnt_next;
      ff_reg <= ff_next;
      irq_reg <= irq_next;
      run_reg <= run_next;
      init_reg <= init_next;
      dlo_reg <= dlo_next;
      dhi_reg <= dhi_next;
    end
  end

  assign count_value = cnt_reg;
  assign match_overflow_interrupt = irq_reg;
  assign output_flipflop = ff_reg;
  assign pwm_output_pin = !ff_reg;
  assign duty_value_low = dlo_reg;
  assign duty_value_high = dhi_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_match_clear;
    @(posedge clk) disable iff (!resetn)
      (run && step && !is_pwm && (cnt_reg + `CTP_CNT_ONE) == match_val)
      |=> (cnt_reg == `CTP_CNT_RST) && match_overflow_interrupt;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("match did not clear");

  property p_count_up;
    @(posedge clk) disable iff (!resetn)
      (run && step && !is_pwm && (cnt_reg + `CTP_CNT_ONE) != match_val)
      |=> cnt_reg == $past(cnt_reg) + `CTP_CNT_ONE;
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step");

  property p_hold_idle;
    @(posedge clk) disable iff (!resetn)
      (run && !step) |=> $stable(cnt_reg);
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("counter moved without source");

  property p_pwm_ovf;
    @(posedge clk) disable iff (!resetn)
      (run && step && is_pwm && cnt_reg == `CTP_CNT_MAX)
      |=> match_overflow_interrupt && cnt_reg == `CTP_CNT_RST && ff_reg != $past(ff_reg);
  endproperty
  a_pwm_ovf: assert property (p_pwm_ovf) else $error("pwm overflow wrong");

  property p_pwm_duty;
    @(posedge clk) disable iff (!resetn)
      (run && step && is_pwm && cnt_reg != `CTP_CNT_MAX && cnt_reg + `CTP_CNT_ONE == duty_act_reg)
      |=> ff_reg != $past(ff_reg) && !match_overflow_interrupt;
  endproperty
  a_pwm_duty: assert property (p_pwm_duty) else $error("duty match did not toggle");

  property p_pin_inverse;
    @(posedge clk) disable iff (!resetn) pwm_output_pin != output_flipflop;
  endproperty
  a_pin_inverse: assert property (p_pin_inverse) else $error("pin not inverse");

  property p_stop_hold;
    @(posedge clk) disable iff (!resetn)
      (run_reg && !run) |=> ff_reg == $past(ff_reg);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop changed pin");

  property p_stop_xfer;
    @(posedge clk) disable iff (!resetn)
      (!run && duty_value_low_wr) ##1 !run |-> duty_act_reg[7:0] == $past(wr_data);
  endproperty
  a_stop_xfer: assert property (p_stop_xfer) else $error("stopped duty not moved");

  property p_run_buffer;
    @(posedge clk) disable iff (!resetn)
      (run && is_pwm && !(step && cnt_reg == `CTP_CNT_MAX)) |=> $stable(duty_act_reg);
  endproperty
  a_run_buffer: assert property (p_run_buffer) else $error("duty moved mid-period");

  property p_irq_cause;
    @(posedge clk) disable iff (!resetn)
      match_overflow_interrupt |-> $past(run && step);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without count step");

  property p_pwm_quiet;
    @(posedge clk) disable iff (!resetn)
      (run && is_pwm && !(step && cnt_reg == `CTP_CNT_MAX)
        && !(step && cnt_reg + `CTP_CNT_ONE == duty_act_reg))
      |=> $stable(ff_reg);
  endproperty
  a_pwm_quiet: assert property (p_pwm_quiet) else $error("pwm flip-flop moved off match");

  property p_stop_keep;
    @(posedge clk) disable iff (!resetn)
      (!run && !run_reg && ff_init == init_reg)
      |=> $stable(output_flipflop);
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("stopped level not held");

  property p_init_load;
    @(posedge clk) disable iff (!resetn)
      (!run && !run_reg && ff_init != init_reg)
      |=> output_flipflop == $past(ff_init);
  endproperty
  a_init_load: assert property (p_init_load) else $error("init bit not loaded");
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import ctp_pkg::*;
;
  logic clk, resetn, slow_mode, divider_source_select, fs_tick, external_count_pin;
  logic [7:0] lower_counter_control, upper_counter_control, wr_data;
  logic match_value_low_wr, match_value_high_wr, duty_value_low_wr, duty_value_high_wr;
  ctp_mode_e mode;
  logic [7:0] duty_value_low, duty_value_high;
  logic [15:0] count_value;
  logic match_overflow_interrupt, pwm_output_pin, output_flipflop;
  int bad_count, compares, fs_div, n;
  logic [15:0] d1, d2;

  ctp_timer dut_u (.clk(clk), .resetn(resetn), .lower_counter_control(lower_counter_control),
    .upper_counter_control(upper_counter_control), .mode(mode), .slow_mode(slow_mode),
    .divider_source_select(divider_source_select), .fs_tick(fs_tick),
    .external_count_pin(external_count_pin), .wr_data(wr_data),
    .match_value_low_wr(match_value_low_wr), .match_value_high_wr(match_value_high_wr),
    .duty_value_low_wr(duty_value_low_wr), .duty_value_high_wr(duty_value_high_wr),
    .duty_value_low(duty_value_low), .duty_value_high(duty_value_high),
    .count_value(count_value), .match_overflow_interrupt(match_overflow_interrupt),
    .pwm_output_pin(pwm_output_pin), .output_flipflop(output_flipflop));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // low-frequency tick, one pulse every five cycles
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      fs_div <= 0;
      fs_tick <= 1'b0;
    end else begin
      fs_div <= (fs_div == 4) ? 0 : fs_div + 1;
      fs_tick <= (fs_div == 4);
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_irq(output int cyc, input int lim);
    cyc = 0;
    do begin
      @(posedge clk);
      cyc++;
    end while (match_overflow_interrupt !== 1'b1 && cyc < lim);
    if (match_overflow_interrupt !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic wait_cnt(input logic [15:0] t, input int lim);
    int c;
    c = 0;
    while (count_value !== t && c < lim) begin
      @(posedge clk);
      c++;
    end
    if (count_value !== t) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  // low byte first, then high byte
  task automatic wr16(input logic duty, input logic [15:0] v);
    @(posedge clk);
    wr_data <= v[7:0];
    match_value_low_wr <= ~duty;
    duty_value_low_wr <= duty;
    @(posedge clk);
    wr_data <= v[15:8];
    match_value_low_wr <= 1'b0;
    duty_value_low_wr <= 1'b0;
    match_value_high_wr <= ~duty;
    duty_value_high_wr <= duty;
    @(posedge clk);
    match_value_high_wr <= 1'b0;
    duty_value_high_wr <= 1'b0;
  endtask

  // irq spacing equals match times source divide
  task automatic period_test(input logic [2:0] sel, input logic dss, input logic slw,
                             input int div, input logic [15:0] m);
    @(posedge clk);
    upper_counter_control <= 8'h00;
    wr16(1'b0, m);
    @(posedge clk);
    mode <= CTP_MODE_TIMER;
    lower_counter_control <= {1'b0, sel, 4'h0};
    divider_source_select <= dss;
    slow_mode <= slw;
    upper_counter_control <= 8'h08;
    wait_irq(n, 20000);
    wait_irq(n, 20000);
    chk("timer period", 16'(m * div), 16'(n));
  endtask

  // count rate of a pwm source over 40 running cycles
  task automatic rate_test(input logic [2:0] sel, input logic [15:0] exp);
    @(posedge clk);
    upper_counter_control <= 8'h00;
    lower_counter_control <= {1'b0, sel, 4'h0};
    @(posedge clk);
    upper_counter_control <= 8'h08;
    repeat (41) @(posedge clk);
    chk("pwm rate", exp, count_value);
  endtask

  initial begin
    bad_count = 0;
    compares = 0;
    resetn = 1'b0;
    slow_mode = 1'b0;
    divider_source_select = 1'b0;
    external_count_pin = 1'b1;
    lower_counter_control = 8'h00;
    upper_counter_control = 8'h00;
    wr_data = 8'h00;
    match_value_low_wr = 1'b0;
    match_value_high_wr = 1'b0;
    duty_value_low_wr = 1'b0;
    duty_value_high_wr = 1'b0;
    mode = CTP_MODE_TIMER;
    void'($urandom(32'hed6a));
    repeat (8) @(posedge clk);
    chk("reset pin", 16'h0001, {15'h0, pwm_output_pin});
    chk("reset ff", 16'h0000, {15'h0, output_flipflop});
    chk("reset count", 16'h0000, count_value);
    resetn <= 1'b1;

    // ------------------------------------------------------------
    // interval timer, every source
    // ------------------------------------------------------------
    period_test(3'd0, 1'b0, 1'b0, 2048, 16'(1 + $urandom % 3));
    period_test(3'd1, 1'b0, 1'b0, 128, 16'(1 + $urandom % 8));
    period_test(3'd2, 1'b0, 1'b0, 32, 16'(1 + $urandom % 16));
    period_test(3'd3, 1'b0, 1'b0, 8, 16'h0102);
    period_test(3'd0, 1'b1, 1'b0, 40, 16'(1 + $urandom % 8));
    period_test(3'd0, 1'b0, 1'b1, 40, 16'(1 + $urandom % 8));

    // ------------------------------------------------------------
    // event counter: seven falls, match three
    // ------------------------------------------------------------
    @(posedge clk);
    upper_counter_control <= 8'h00;
    slow_mode <= 1'b0;
    wr16(1'b0, 16'h0003);
    @(posedge clk);
    mode <= CTP_MODE_EVENT;
    upper_counter_control <= 8'h08;
    n = 0;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      external_count_pin <= 1'b0;
      for (int k = 0; k < 2 + $urandom % 4; k++) begin
        @(posedge clk);
        if (match_overflow_interrupt === 1'b1) n++;
      end
      external_count_pin <= 1'b1;
      for (int k = 0; k < 2 + $urandom % 4; k++) begin
        @(posedge clk);
        if (match_overflow_interrupt === 1'b1) n++;
      end
    end
    repeat (10) begin
      @(posedge clk);
      if (match_overflow_interrupt === 1'b1) n++;
    end
    chk("event irqs", 16'h0002, 16'(n));
    chk("event count", 16'h0001, count_value);

    // ------------------------------------------------------------
    // pwm on fc: one full period, buffered duty, stop behaviour
    // ------------------------------------------------------------
    d1 = 16'h0100 + 16'($urandom % 256);
    d2 = 16'h0002 + 16'($urandom % 64);
    @(posedge clk);
    upper_counter_control <= 8'h00;
    mode <= CTP_MODE_PWM;
    lower_counter_control <= {1'b0, 3'd6, 4'h0};
    wr16(1'b1, d1);
    repeat (3) @(posedge clk);
    chk("duty stopped", d1, {duty_value_high, duty_value_low});
    upper_counter_control <= 8'h08;
    wait_cnt(d1 - 16'h0001, 1000);
    chk("ff before duty", 16'h0000, {15'h0, output_flipflop});
    wait_cnt(d1 + 16'h0001, 100);
    chk("ff at duty", 16'h0001, {15'h0, output_flipflop});
    chk("pin at duty", 16'h0000, {15'h0, pwm_output_pin});
    wr16(1'b1, d2);
    repeat (3) @(posedge clk);
    chk("duty read old", d1, {duty_value_high, duty_value_low});
    wait_irq(n, 70000);
    chk("ff overflow", 16'h0000, {15'h0, output_flipflop});
    chk("count overflow", 16'h0000, count_value);
    repeat (3) @(posedge clk);
    chk("duty read new", d2, {duty_value_high, duty_value_low});
    wait_cnt(d2 + 16'h0001, 200);
    chk("ff new duty", 16'h0001, {15'h0, output_flipflop});
    @(posedge clk);
    upper_counter_control <= 8'h00;
    repeat (4) @(posedge clk);
    chk("pin held", 16'h0000, {15'h0, pwm_output_pin});
    upper_counter_control <= 8'h80;
    repeat (3) @(posedge clk);
    chk("ff init one", 16'h0001, {15'h0, output_flipflop});
    upper_counter_control <= 8'h00;
    repeat (3) @(posedge clk);
    chk("pin forced high", 16'h0001, {15'h0, pwm_output_pin});
    rate_test(3'd4, 16'h0008);
    rate_test(3'd5, 16'h0014);
    tally_and_finish();
  end
endmodule
`default_nettype wire
